// ===== rtl/pchs_defs.svh
/*
 * Offsets, field positions and fixed values of the configuration header slice.
 * Assumes inclusion by bare name from the register bank and the bench.
 */
`ifndef PCHS_DEFS_SVH
`define PCHS_DEFS_SVH

`define PCHS_OFS_STATUS      8'h06
`define PCHS_OFS_REVISION    8'h08
`define PCHS_OFS_SUBCLASS    8'h0A
`define PCHS_OFS_BASECLASS   8'h0B
`define PCHS_OFS_HEADER      8'h0E

`define PCHS_ST_PARERR_BIT   15
`define PCHS_ST_SYSERR_BIT   14
`define PCHS_ST_RMA_BIT      13
`define PCHS_ST_RTA_BIT      12
`define PCHS_ST_STA_BIT      11
`define PCHS_ST_DEVSEL_HI    10
`define PCHS_ST_DEVSEL_LO    9
`define PCHS_ST_MDPE_BIT     8
`define PCHS_ST_B2B_BIT      7
`define PCHS_ST_CAPLIST_BIT  4

`define PCHS_STATUS_RESET    16'h0080
`define PCHS_DEVSEL_FAST     2'h0
// Arbitrary revision code, not tied to any real silicon step
`define PCHS_REVISION_VALUE  8'h5A
`define PCHS_SUBCLASS_VALUE  8'h80
`define PCHS_BASECLASS_VALUE 8'h08
`define PCHS_HEADER_MULTI    8'h80
`define PCHS_HEADER_SINGLE   8'h00

`endif

// ===== rtl/pchs_pkg.sv
/*
 * Types shared by the configuration header slice.
 * Assumes a configuration access port that presents byte offset and data.
 */
package pchs_pkg;
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] offset;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} pchs_cfg_req_t;

	typedef enum logic {
		PCHS_IDLE,
		PCHS_ANSWER
	} pchs_state_t;
endpackage

// ===== rtl/pchs_status_class.sv
/*
 * Status, revision, class and header-type slice of a function's configuration
 * header. Assumes requests come from logic on clk_i, at most one access every two cycles, and
 * that offsets are byte offsets into the header; data lanes follow byte_en, offset[1:0] unused.
 * Writes are acknowledged and dropped; no software state is held here.
 */
`timescale 1ns/1ps
`include "pchs_defs.svh"

// Functional notes
// - Parity and system error bits read zero
// - Abort status bits constant zero, writes ignored
// - Devsel timing field always reads 00
// - Fast back-to-back bit always reads one
// - Capability list bit reads zero
// - Clearing system error bit leaves it zero
// - Status register reads 0080h after reset
// - Revision fixed, writes discarded
// - Subclass reads 80h constant
// - Base class reads 08h constant
// - Header type 80h, 00h if others disabled
// - Header type has no storage or effects
module pchs_status_class
	import pchs_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          arst_n_i,
	// Configuration access
	input  wire pchs_cfg_req_t cfg_req_i,
	output logic               cfg_ack_o,
	output logic [31:0]        cfg_rdata_o,
	// Function strap from pins
	input  wire logic          other_funcs_off_i
);

	logic        off_meta_q;
	logic        off_sync_q;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [15:0] status_q;
	pchs_state_t state_q;
	logic        take_rd;
	logic        take_wr;

	// Status value has no writable bit; every position is fixed
	function automatic logic [15:0] status_word();
		logic [15:0] s;
		s = 16'h0000;
		s[`PCHS_ST_PARERR_BIT] = 1'b0;
		s[`PCHS_ST_SYSERR_BIT] = 1'b0;
		s[`PCHS_ST_MDPE_BIT] = 1'b0;
		s[`PCHS_ST_RMA_BIT]  = 1'b0;
		s[`PCHS_ST_RTA_BIT]  = 1'b0;
		s[`PCHS_ST_STA_BIT]  = 1'b0;
		s[`PCHS_ST_DEVSEL_HI:`PCHS_ST_DEVSEL_LO] = `PCHS_DEVSEL_FAST;
		s[`PCHS_ST_B2B_BIT] = 1'b1;
		s[`PCHS_ST_CAPLIST_BIT] = 1'b0;
		return s;
	endfunction

	// Byte value at one header offset, zero outside this slice
	function automatic logic [7:0] byte_at(input logic [7:0] ofs, input logic [15:0] st,
		input logic single);
		logic [7:0] v;
		v = 8'h00;
		if (ofs == `PCHS_OFS_STATUS) begin
			v = st[7:0];
		end else if (ofs == (`PCHS_OFS_STATUS + 8'h01)) begin
			v = st[15:8];
		end else if (ofs == `PCHS_OFS_REVISION) begin
			v = `PCHS_REVISION_VALUE;
		end else if (ofs == `PCHS_OFS_SUBCLASS) begin
			v = `PCHS_SUBCLASS_VALUE;
		end else if (ofs == `PCHS_OFS_BASECLASS) begin
			v = `PCHS_BASECLASS_VALUE;
		end else if (ofs == `PCHS_OFS_HEADER) begin
			v = single ? `PCHS_HEADER_SINGLE : `PCHS_HEADER_MULTI;
		end
		return v;
	endfunction

	// True when a byte offset lies in the dword holding a register
	function automatic logic in_dword(input logic [7:0] ofs, input logic [7:0] reg_ofs);
		return ofs[7:2] == reg_ofs[7:2];
	endfunction

	// Strap arrives asynchronously; two stages before use
	// Header byte therefore trails a strap change by two edges
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			off_meta_q <= 1'b0;
			off_sync_q <= 1'b0;
		end else begin
			off_meta_q <= other_funcs_off_i;
			off_sync_q <= off_meta_q;
		end
	end

	// Writes never reach this register; hardwired bits win over clears
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_q <= `PCHS_STATUS_RESET;
		end else begin
			status_q <= status_word();
		end
	end

	// One-cycle answer to every read or write; writes only get an ack
	// Requests in the answer cycle are dropped, not queued; callers space them
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= PCHS_IDLE;
			ack_q   <= 1'b0;
		end else begin
			case (state_q)
				PCHS_IDLE: begin
					ack_q <= cfg_req_i.rd | cfg_req_i.wr;
					if (cfg_req_i.rd | cfg_req_i.wr) begin
						state_q <= PCHS_ANSWER;
					end
				end
				PCHS_ANSWER: begin
					ack_q   <= 1'b0;
					state_q <= PCHS_IDLE;
				end
				default: begin
					ack_q   <= 1'b0;
					state_q <= PCHS_IDLE;
				end
			endcase
		end
	end

	// Read data per lane; header read has no side effect
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (state_q == PCHS_IDLE && cfg_req_i.rd) begin
			for (int i = 0; i < 4; i++) begin
				rdata_q[i*8 +: 8] <= cfg_req_i.byte_en[i] ?
					byte_at({cfg_req_i.offset[7:2], 2'(i)}, status_q, off_sync_q) : 8'h00;
			end
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign cfg_ack_o   = ack_q;
	assign cfg_rdata_o = rdata_q;

	// Requests taken at this edge; the checks below key off them
	assign take_rd = (state_q == PCHS_IDLE) && cfg_req_i.rd;
	assign take_wr = (state_q == PCHS_IDLE) && cfg_req_i.wr && !cfg_req_i.rd;

	// Stored status never leaves its hardwired value
	a_status_fixed: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_q == `PCHS_STATUS_RESET) else $error("status word changed");
	a_status_errors: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_q[15:8] == 8'h00) else $error("error bit set");
	a_syserr_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cfg_req_i.wr |=> ##1 !status_q[`PCHS_ST_SYSERR_BIT])
		else $error("system error bit set");
	a_status_aborts: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cfg_req_i.wr |=> $stable(status_q[13:11])) else $error("abort bits moved");

	// Status as it appears on lanes 2 and 3
	a_devsel_fast: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_STATUS) && cfg_req_i.byte_en[3])
		|=> cfg_rdata_o[26:25] == `PCHS_DEVSEL_FAST) else $error("devsel timing not fast");
	a_fast_b2b: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_STATUS) && cfg_req_i.byte_en[2])
		|=> cfg_rdata_o[23]) else $error("back-to-back bit clear");
	a_status_upper: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_STATUS) && cfg_req_i.byte_en[3])
		|=> cfg_rdata_o[31:27] == 5'h00 && !cfg_rdata_o[24]) else $error("error bit read as set");
	a_capability_none: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_STATUS) && cfg_req_i.byte_en[2])
		|=> !cfg_rdata_o[20]) else $error("capability list bit set");
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_STATUS) && cfg_req_i.byte_en[2])
		|=> cfg_rdata_o[22:16] == 7'h00) else $error("reserved status bit set");

	// Revision, class and header bytes
	a_class_codes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && cfg_req_i.offset == 8'h08 && cfg_req_i.byte_en == 4'hF)
		|=> cfg_rdata_o[31:16] == 16'h0880 && cfg_rdata_o[7:0] == `PCHS_REVISION_VALUE)
		else $error("class or revision bad");
	a_revision_fixed: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_REVISION) && cfg_req_i.byte_en[0])
		|=> cfg_rdata_o[7:0] == `PCHS_REVISION_VALUE) else $error("revision byte bad");
	a_subclass_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_SUBCLASS) && cfg_req_i.byte_en[2])
		|=> cfg_rdata_o[23:16] == `PCHS_SUBCLASS_VALUE) else $error("subclass byte bad");
	a_base_class: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_BASECLASS) && cfg_req_i.byte_en[3])
		|=> cfg_rdata_o[31:24] == `PCHS_BASECLASS_VALUE) else $error("base class byte bad");
	a_header_type: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(take_rd && in_dword(cfg_req_i.offset, `PCHS_OFS_HEADER) && cfg_req_i.byte_en[2])
		|=> cfg_rdata_o[23:16] == ($past(off_sync_q) ? `PCHS_HEADER_SINGLE : `PCHS_HEADER_MULTI))
		else $error("header bad");

	// One answer per taken request, data only beside it
	a_ack_follows: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state_q == PCHS_IDLE && (cfg_req_i.rd || cfg_req_i.wr)) |=> cfg_ack_o)
		else $error("request not answered");
	a_ack_once: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cfg_ack_o |=> !cfg_ack_o) else $error("ack longer than one cycle");
	a_busy_refused: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state_q == PCHS_ANSWER && (cfg_req_i.rd || cfg_req_i.wr))
		|=> !cfg_ack_o && cfg_rdata_o == 32'h0000_0000)
		else $error("request in answer cycle taken");
	a_rdata_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!cfg_ack_o |-> cfg_rdata_o == 32'h0000_0000) else $error("data without ack");
	a_write_no_data: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		take_wr |=> cfg_rdata_o == 32'h0000_0000) else $error("write returned data");

	// Disabled lanes read zero whatever the offset
	for (genvar g = 0; g < 4; g++) begin : g_lane
		a_lane_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
			(take_rd && !cfg_req_i.byte_en[g]) |=> cfg_rdata_o[g*8 +: 8] == 8'h00)
			else $error("disabled lane not zero");
	end

endmodule // pchs_status_class

// ===== testbench/tb.sv
/*
 * Self-checking bench for the status, class and header-type slice.
 * Assumes the design files under rtl/ and a 250 MHz clock.
 */
`timescale 1ns/1ps
`include "pchs_defs.svh"
module tb
	import pchs_pkg::*;
;
	typedef struct {
		logic        wr;
		logic [7:0]  off;
		logic [3:0]  be;
		logic        strap;
		logic [31:0] exp;
	} pchs_row_t;
	logic          clk_i;
	logic          arst_n_i;
	pchs_cfg_req_t cfg_req_i;
	logic          cfg_ack_o;
	logic [31:0]   cfg_rdata_o;
	logic          other_funcs_off_i;
	int            errors;
	int            checked;
	logic [31:0]   rd_q;
	pchs_row_t     rows [11];

	pchs_status_class u_dut (
		.clk_i             (clk_i),
		.arst_n_i          (arst_n_i),
		.cfg_req_i         (cfg_req_i),
		.cfg_ack_o         (cfg_ack_o),
		.cfg_rdata_o       (cfg_rdata_o),
		.other_funcs_off_i (other_funcs_off_i)
	);

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held one cycle, answer sampled the cycle after
	task automatic access(input logic wr, input logic [7:0] off, input logic [3:0] be,
			output logic [31:0] data);
		@(posedge clk_i);
		#1;
		cfg_req_i = '{rd: !wr, wr: wr, offset: off, byte_en: be, wdata: 32'hFFFF_FFFF};
		@(posedge clk_i);
		#1;
		cfg_req_i = '0;
		check("ack", {31'h0, cfg_ack_o}, 32'h0000_0001);
		data = cfg_rdata_o;
		@(posedge clk_i);
		#1;
		check("ack_end", {31'h0, cfg_ack_o}, 32'h0000_0000);
		check("rdata_end", cfg_rdata_o, 32'h0000_0000);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#20000;
		errors++;
		results();
	end

	initial begin
		rows = '{
			'{1'b0, 8'h04, 4'hF, 1'b0, 32'h0080_0000},
			'{1'b1, 8'h06, 4'hF, 1'b0, 32'h0080_0000},
			'{1'b0, 8'h04, 4'h3, 1'b0, 32'h0000_0000},
			'{1'b0, 8'h08, 4'hF, 1'b0, {`PCHS_BASECLASS_VALUE, `PCHS_SUBCLASS_VALUE,
				8'h00, `PCHS_REVISION_VALUE}},
			'{1'b1, 8'h08, 4'h1, 1'b0, {24'h00_0000, `PCHS_REVISION_VALUE}},
			'{1'b0, 8'h0A, 4'h4, 1'b0, {8'h00, `PCHS_SUBCLASS_VALUE, 16'h0000}},
			'{1'b0, 8'h0B, 4'h8, 1'b0, {`PCHS_BASECLASS_VALUE, 24'h00_0000}},
			'{1'b0, 8'h0E, 4'hF, 1'b0, {8'h00, `PCHS_HEADER_MULTI, 16'h0000}},
			'{1'b1, 8'h0E, 4'h4, 1'b0, {8'h00, `PCHS_HEADER_MULTI, 16'h0000}},
			'{1'b0, 8'h0C, 4'hF, 1'b1, {8'h00, `PCHS_HEADER_SINGLE, 16'h0000}},
			'{1'b0, 8'h00, 4'hF, 1'b1, 32'h0000_0000}
		};
		cfg_req_i = '0;
		other_funcs_off_i = 1'b0;
		arst_n_i = 1'b0;
		errors = 0;
		checked = 0;
		repeat (16) @(posedge clk_i);
		#1;
		check("ack_in_reset", {31'h0, cfg_ack_o}, 32'h0000_0000);
		arst_n_i = 1'b1;
		access(1'b0, 8'h04, 4'hF, rd_q);
		check("status_reset", rd_q, 32'h0080_0000);
		$display("reset test done");
		foreach (rows[i]) begin
			other_funcs_off_i = rows[i].strap;
			repeat (4) @(posedge clk_i);
			#1;
			if (rows[i].wr) begin
				access(1'b1, rows[i].off, rows[i].be, rd_q);
				check("write_rdata", rd_q, 32'h0000_0000);
			end
			access(1'b0, rows[i].off, rows[i].be, rd_q);
			check("row_rdata", rd_q, rows[i].exp);
			$display("row %0d done", i);
		end
		// Read held over two edges: the second falls in the answer cycle
		@(posedge clk_i);
		#1;
		cfg_req_i = '{rd: 1'b1, wr: 1'b0, offset: `PCHS_OFS_REVISION, byte_en: 4'h1,
			wdata: 32'h0000_0000};
		@(posedge clk_i);
		#1;
		check("held_ack", {31'h0, cfg_ack_o}, 32'h0000_0001);
		check("held_rdata", cfg_rdata_o, {24'h00_0000, `PCHS_REVISION_VALUE});
		@(posedge clk_i);
		#1;
		cfg_req_i = '0;
		check("refused_ack", {31'h0, cfg_ack_o}, 32'h0000_0000);
		check("refused_rdata", cfg_rdata_o, 32'h0000_0000);
		$display("refused request test done");
		// Reset in mid-run, strap still high: single-function header after release
		arst_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		check("rdata_in_reset", cfg_rdata_o, 32'h0000_0000);
		arst_n_i = 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		access(1'b0, 8'h0C, 4'hF, rd_q);
		check("header_after_reset", rd_q, 32'h0000_0000);
		$display("mid-run reset test done");
		results();
	end
endmodule // tb
